//--- rtl/pfm_pin_mux.sv
// Pin function multiplexer with reset-time mode straps.
// Assumes core logic on core_clk drives the internal side; pins are
// split into input, output and output enable (enable low = driving).
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_mux
  import pfm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Strap / programmable flag 0..3 pins
  input wire logic [3:0] strap_flag_in,
  output logic [3:0] strap_flag_out,
  output logic [3:0] strap_flag_oe_n,
  // Core flag control for flags 0..3
  input wire logic [3:0] core_flag_lo_out,
  input wire logic [3:0] core_flag_lo_dir,
  output logic [3:0] core_flag_lo_in,
  // Shared irq / flag 4..7 pins
  input wire logic [3:0] irq_flag_in,
  output logic [3:0] irq_flag_out,
  output logic [3:0] irq_flag_oe_n,
  input wire logic [3:0] core_flag_hi_out,
  input wire logic [3:0] core_flag_hi_dir,
  output logic [3:0] core_flag_hi_in,
  // Interrupt mask and requests to the sequencer
  input wire logic [3:0] interrupt_mask,
  output pfm_irq_s irq_request,
  // Mode status
  output pfm_mode_e mode,
  output logic byte_dma_en,
  output logic host_dma_en,
  output logic [3:0] strap_value,
  // External address and data pins
  output logic [13:0] ext_address_out,
  output logic ext_address_oe_n,
  input wire logic [23:0] ext_data_in,
  output logic [23:0] ext_data_out,
  output logic [23:0] ext_data_oe_n,
  // Core memory interface
  input wire logic [13:0] core_addr,
  input wire logic [23:0] core_wdata,
  input wire logic core_drive_data,
  output logic [23:0] core_rdata,
  // Host port, core side
  input wire logic [15:0] host_rdata,
  input wire logic host_drive,
  input wire logic host_ack,
  output logic [15:0] host_addr_data_bus,
  output pfm_host_ctl_s host_ctl,
  // Open-drain host acknowledge pin
  output logic host_acknowledge_out,
  output logic host_acknowledge_oe_n,
  // Serial port one pins and control
  input wire pfm_sport_cfg_s sport_cfg,
  input wire logic [2:0] sport_pin_in,
  input wire logic sport_core_dt,
  input wire logic serial_flag_out,
  output logic sport_dt_out,
  output logic serial_flag_in,
  output logic [2:0] sport_core_in,
  output logic [1:0] sport_irq
);

  logic [3:0] strap_ff;
  logic rst_seen_ff;
  logic [3:0] strap_sync;
  logic [3:0] irqpin_sync;
  logic [23:0] data_sync;
  logic [2:0] sport_sync;
  // Strap synchroniser is never reset: it must track the pins while
  // reset is held, or the capture below would only ever see zeros.
  wire strap_sync_rst = 1'b0;

  pfm_sync #(.W(4)) u_sync_strap (
    .core_clk(core_clk), .rst(strap_sync_rst), .din(strap_flag_in),
    .dout(strap_sync));
  pfm_sync #(.W(4)) u_sync_irq (
    .core_clk(core_clk), .rst(rst), .din(irq_flag_in),
    .dout(irqpin_sync));
  pfm_sync #(.W(24)) u_sync_data (
    .core_clk(core_clk), .rst(rst), .din(ext_data_in),
    .dout(data_sync));
  pfm_sync #(.W(3)) u_sync_sport (
    .core_clk(core_clk), .rst(rst), .din(sport_pin_in),
    .dout(sport_sync));

  // Straps caught on the first edge after release; raw pins are asynchronous
  // to reset, so the synchronised copy is used. Pins stay input until then.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_seen_ff <= 1'b0;
      strap_ff <= 4'h0;
    end else if (!rst_seen_ff) begin
      rst_seen_ff <= 1'b1;
      strap_ff <= strap_sync;
    end
  end

  wire is_host = strap_ff[`PFM_STRAP_C] & rst_seen_ff;
  wire ack_open_drain = strap_ff[`PFM_STRAP_D];

  // Flags 0..3 only after strap capture
  wire [3:0] nxt_strap_oe_n = rst_seen_ff ? ~core_flag_lo_dir : 4'hf;
  // Flag outputs stay on the pin while the irq sees the pin level
  wire [3:0] irq_level = irqpin_sync;
  // Pins are active low; a low level requests while masked in
  wire [3:0] nxt_irq_req = ~irq_level & interrupt_mask;

  // Full mode: 14 address, 24 data; host: A0 plus upper 16 data
  wire [13:0] nxt_addr = is_host ? {13'h0000, core_addr[0]} : core_addr;
  wire [23:0] full_oe_n = core_drive_data ? `PFM_ZERO_DATA : 24'hffffff;
  wire [7:0] host_lo_oe_n = host_drive ? 8'h00 : 8'hff;
  wire [23:0] nxt_data_oe_n = is_host
    ? {full_oe_n[23:8], host_lo_oe_n} : full_oe_n;
  wire [23:0] nxt_data_out = is_host
    ? {core_wdata[23:8], host_rdata[7:0]} : core_wdata;
  // Host bus bits 15..8 come from core_addr 13..6, bits 7..0 from data pins 7..0
  wire [15:0] nxt_host_bus = {core_addr[13:6], data_sync[7:0]};

  // Host strobes mapped from low data pins, gated in full mode
  wire [3:0] strobe_raw = data_sync[7:4];
  // so a full-mode part never shows a phantom host access
  wire [3:0] nxt_host_ctl = is_host ? strobe_raw : `PFM_HOST_IDLE;

  // Acknowledge: open drain pulls low only; push-pull when strap D clear
  // Open drain idles released, so the board pull-up sets the level
  wire nxt_ack_oe_n = ~is_host ? 1'b1
    : (ack_open_drain ? ~host_ack : 1'b0);
  wire nxt_ack_out = ack_open_drain ? 1'b0 : ~host_ack;

  // Serial port one alternate functions, reselectable at any time
  wire [1:0] nxt_sport_irq = {sport_cfg.irq1_sel & ~sport_sync[1],
                              sport_cfg.irq0_sel & ~sport_sync[0]};
  wire nxt_flag_in = sport_cfg.flag_in_sel & sport_sync[2];
  // Data pin doubles as the output flag when software asks for it
  wire nxt_dt = sport_cfg.flag_out_sel ? serial_flag_out : sport_core_dt;
  wire [2:0] nxt_sport_core = {sport_cfg.flag_in_sel ? 1'b0 : sport_sync[2],
                               sport_cfg.irq1_sel ? 1'b0 : sport_sync[1],
                               sport_cfg.irq0_sel ? 1'b0 : sport_sync[0]};

  // Every top output below comes from a flop; mode and host_dma_en share mode_ff
  logic [3:0] strap_oe_ff, strap_out_ff, lo_in_ff;
  logic [3:0] irq_oe_ff, irq_out_ff, hi_in_ff, irq_req_ff;
  logic [13:0] addr_ff;
  logic addr_oe_ff;
  logic [23:0] dout_ff, doe_ff, rdata_ff;
  logic [15:0] host_bus_ff;
  logic [3:0] host_ctl_ff;
  logic ack_out_ff, ack_oe_ff;
  logic [1:0] sirq_ff;
  logic fin_ff, dt_ff;
  logic [2:0] score_ff;
  logic mode_ff;
  logic byte_dma_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_oe_ff <= 4'hf;
      strap_out_ff <= 4'h0;
      lo_in_ff <= 4'h0;
      irq_oe_ff <= 4'hf;
      irq_out_ff <= 4'h0;
      hi_in_ff <= 4'h0;
      irq_req_ff <= 4'h0;
    end else begin
      strap_oe_ff <= nxt_strap_oe_n;
      strap_out_ff <= core_flag_lo_out;
      lo_in_ff <= rst_seen_ff ? strap_sync : 4'h0;
      irq_oe_ff <= ~core_flag_hi_dir;
      irq_out_ff <= core_flag_hi_out;
      hi_in_ff <= irq_level;
      irq_req_ff <= nxt_irq_req;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_ff <= `PFM_ZERO_ADDR;
      addr_oe_ff <= 1'b1;
      dout_ff <= `PFM_ZERO_DATA;
      doe_ff <= 24'hffffff;
      rdata_ff <= `PFM_ZERO_DATA;
      host_bus_ff <= `PFM_ZERO_HOST;
      host_ctl_ff <= `PFM_HOST_IDLE;
      mode_ff <= 1'b0;
      byte_dma_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      addr_oe_ff <= ~rst_seen_ff;
      dout_ff <= nxt_data_out;
      doe_ff <= rst_seen_ff ? nxt_data_oe_n : 24'hffffff;
      rdata_ff <= is_host ? {data_sync[23:8], 8'h00} : data_sync;
      host_bus_ff <= is_host ? nxt_host_bus : `PFM_ZERO_HOST;
      host_ctl_ff <= nxt_host_ctl;
      mode_ff <= is_host;
      // Byte DMA only once pins are live and the part is in full mode
      byte_dma_ff <= rst_seen_ff & ~strap_ff[`PFM_STRAP_C];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_out_ff <= 1'b0;
      ack_oe_ff <= 1'b1;
      sirq_ff <= 2'b00;
      fin_ff <= 1'b0;
      dt_ff <= 1'b0;
      score_ff <= 3'h0;
    end else begin
      ack_out_ff <= nxt_ack_out;
      ack_oe_ff <= nxt_ack_oe_n;
      sirq_ff <= nxt_sport_irq;
      fin_ff <= nxt_flag_in;
      dt_ff <= nxt_dt;
      score_ff <= nxt_sport_core;
    end
  end

  assign strap_flag_oe_n = strap_oe_ff;
  assign strap_flag_out = strap_out_ff;
  assign core_flag_lo_in = lo_in_ff;
  assign irq_flag_oe_n = irq_oe_ff;
  assign irq_flag_out = irq_out_ff;
  assign core_flag_hi_in = hi_in_ff;
  assign irq_request = irq_req_ff;
  assign mode = pfm_mode_e'(mode_ff);
  assign host_dma_en = mode_ff;
  assign byte_dma_en = byte_dma_ff;
  assign strap_value = strap_ff;
  assign ext_address_out = addr_ff;
  assign ext_address_oe_n = addr_oe_ff;
  assign ext_data_out = dout_ff;
  assign ext_data_oe_n = doe_ff;
  assign core_rdata = rdata_ff;
  assign host_addr_data_bus = host_bus_ff;
  assign host_ctl = host_ctl_ff;
  assign host_acknowledge_out = ack_out_ff;
  assign host_acknowledge_oe_n = ack_oe_ff;
  assign sport_irq = sirq_ff;
  assign serial_flag_in = fin_ff;
  assign sport_dt_out = dt_ff;
  assign sport_core_in = score_ff;
endmodule
`default_nettype wire

//--- shared/pfm_defines.svh
// Constants for the pin function multiplexer and mode straps.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH
`define PFM_ADDR_W 14
`define PFM_DATA_W 24
`define PFM_HOST_W 16
`define PFM_UPPER_LSB 8
`define PFM_STRAP_A 0
`define PFM_STRAP_B 1
`define PFM_STRAP_C 2
`define PFM_STRAP_D 3
`define PFM_ZERO_ADDR 14'h0000
`define PFM_ZERO_DATA 24'h000000
`define PFM_ZERO_HOST 16'h0000
`define PFM_HOST_IDLE 4'b1101
`endif

//--- shared/pfm_pkg.sv
// Types shared by the pin function multiplexer files.
// Assumes pfm_defines.svh is on the include path.
`include "pfm_defines.svh"
package pfm_pkg;
  typedef enum logic {PFM_FULL_MEM, PFM_HOST} pfm_mode_e;
  typedef struct packed {
    logic host_write_enable_n;
    logic host_read_enable_n;
    logic host_address_latch;
    logic host_select_n;
  } pfm_host_ctl_s;
  typedef struct packed {
    logic irq0_sel;
    logic irq1_sel;
    logic flag_in_sel;
    logic flag_out_sel;
  } pfm_sport_cfg_s;
  typedef struct packed {
    logic edge_or_level_irq;
    logic level_irq_1;
    logic level_irq_0;
    logic edge_irq;
  } pfm_irq_s;
endpackage

//--- rtl/pfm_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pfm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule
`default_nettype wire

//--- verification/pfm_pin_mux_sva.sv
// Port checker for the pin function multiplexer.
// Assumes a bind onto pfm_pin_mux, one clock, reset high.
`timescale 1ns/1ps
`default_nettype none
`include "pfm_defines.svh"
module pfm_pin_mux_sva
  import pfm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Observed ports
  input wire logic [3:0] strap_flag_in,
  input wire logic [3:0] strap_flag_oe_n,
  input wire logic [3:0] core_flag_lo_dir,
  input wire logic [3:0] core_flag_lo_in,
  input wire logic [3:0] irq_flag_in,
  input wire logic [3:0] core_flag_hi_in,
  input wire logic [3:0] interrupt_mask,
  input wire pfm_irq_s irq_request,
  input wire pfm_mode_e mode,
  input wire logic byte_dma_en,
  input wire logic host_dma_en,
  input wire logic [3:0] strap_value,
  input wire logic [13:0] ext_address_out,
  input wire logic ext_address_oe_n,
  input wire logic [13:0] core_addr
);
  logic [2:0] up_ff;
  logic [2:0] nxt_up;
  logic settled;
  // Sync flops need a few edges after release
  assign nxt_up = (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
  assign settled = up_ff >= 3'h5;
  always_ff @(posedge core_clk or posedge rst)
    if (rst) up_ff <= 3'h0;
    else up_ff <= nxt_up;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence irq_steady;
    ($stable(irq_flag_in) && $stable(interrupt_mask)) [*4];
  endsequence
  sequence lo_steady;
    $stable(strap_flag_in) [*4];
  endsequence
  strap_hold_a:
    assert property (up_ff >= 3'h2 |-> $stable(strap_value))
    else $error("straps moved");
  mode_strap_a:
    assert property (up_ff >= 3'h2 |->
      (mode == PFM_HOST) == strap_value[`PFM_STRAP_C])
    else $error("mode wrong");
  dma_sel_a:
    assert property (up_ff >= 3'h3 |->
      host_dma_en == (mode == PFM_HOST) && byte_dma_en != host_dma_en)
    else $error("dma enables wrong");
  irq_cause_a:
    assert property (irq_steady ##0 settled |->
      irq_request == (~irq_flag_in & interrupt_mask))
    else $error("irq request wrong");
  flag_both_a:
    assert property (irq_steady ##0 settled |->
      core_flag_hi_in == irq_flag_in)
    else $error("shared flag lost");
  flag_read_a:
    assert property (lo_steady ##0 settled |->
      core_flag_lo_in == strap_flag_in)
    else $error("flag read wrong");
  flag_dir_a:
    assert property (settled |=>
      strap_flag_oe_n == ~$past(core_flag_lo_dir))
    else $error("flag enable wrong");
  addr_full_a:
    assert property (settled && mode == PFM_FULL_MEM |=>
      ext_address_out == $past(core_addr) && !ext_address_oe_n)
    else $error("address not driven");
endmodule
bind pfm_pin_mux pfm_pin_mux_sva u_pfm_pin_mux_sva (
  .core_clk, .rst, .strap_flag_in, .strap_flag_oe_n, .core_flag_lo_dir,
  .core_flag_lo_in, .irq_flag_in, .core_flag_hi_in, .interrupt_mask,
  .irq_request, .mode, .byte_dma_en, .host_dma_en, .strap_value,
  .ext_address_out, .ext_address_oe_n, .core_addr
);
`default_nettype wire

//--- verification/pfm_board.sv
// Board model: strap resistors and outside drivers on flag pins.
// Assumes oe_n low means the chip drives the pin.
`timescale 1ns/1ps
`default_nettype none
module pfm_board (
  // Levels
  input wire logic [7:0] ext_lvl,
  input wire logic [7:0] chip_out,
  input wire logic [7:0] chip_oe_n,
  output logic [7:0] pin_lvl
);
  // Chip wins where it drives; straps are outside levels
  assign pin_lvl = (chip_oe_n & ext_lvl) |
    (~chip_oe_n & chip_out);
endmodule
`default_nettype wire

//--- verification/test_pfm_pin_mux.sv
// Self-checking bench for the pin function multiplexer.
// Assumes the board model and bound checker compile alongside.
`timescale 1ns/1ps
`default_nettype none
`include "pfm_defines.svh"
module test_pfm_pin_mux
  import pfm_pkg::*;
();
  logic core_clk;
  logic rst;
  logic [127:0] st;
  logic [7:0] ext_lvl;
  logic [7:0] pin_lvl;
  logic [3:0] strap_flag_out, strap_flag_oe_n, irq_flag_out, irq_flag_oe_n;
  logic [3:0] core_flag_lo_in, core_flag_hi_in, strap_value;
  logic [13:0] ext_address_out;
  pfm_irq_s irq_request;
  pfm_mode_e mode;
  logic byte_dma_en, host_dma_en, sport_dt_out;
  logic [23:0] ext_data_out, ext_data_oe_n, core_rdata;
  logic [15:0] host_addr_data_bus;
  pfm_host_ctl_s host_ctl;
  logic ext_address_oe_n, host_acknowledge_out, host_acknowledge_oe_n;
  logic serial_flag_in;
  logic [2:0] sport_core_in;
  logic [1:0] sport_irq;
  int seed, fails, tests_run;
  pfm_pin_mux u_pfm_pin_mux (
    .core_clk, .rst, .strap_flag_in(pin_lvl[3:0]), .strap_flag_out,
    .strap_flag_oe_n, .core_flag_lo_out(st[3:0]), .core_flag_lo_dir(st[7:4]),
    .core_flag_lo_in, .irq_flag_in(pin_lvl[7:4]), .irq_flag_out,
    .irq_flag_oe_n, .core_flag_hi_out(st[11:8]),
    .core_flag_hi_dir(st[15:12]), .core_flag_hi_in,
    .interrupt_mask(st[19:16]), .irq_request, .mode, .byte_dma_en,
    .host_dma_en, .strap_value, .ext_address_out, .ext_address_oe_n,
    .ext_data_in(st[87:64]), .ext_data_out, .ext_data_oe_n,
    .core_addr(st[45:32]), .core_wdata(st[111:88]),
    .core_drive_data(st[29]), .core_rdata, .host_rdata(st[63:48]),
    .host_drive(st[30]), .host_ack(st[31]), .host_addr_data_bus,
    .host_ctl, .host_acknowledge_out, .host_acknowledge_oe_n,
    .sport_cfg(pfm_sport_cfg_s'(st[23:20])), .sport_pin_in(st[26:24]),
    .sport_core_dt(st[27]), .serial_flag_out(st[28]), .sport_dt_out,
    .serial_flag_in, .sport_core_in, .sport_irq
  );
  pfm_board u_pfm_board (
    .ext_lvl, .chip_out({irq_flag_out, strap_flag_out}),
    .chip_oe_n({irq_flag_oe_n, strap_flag_oe_n}), .pin_lvl
  );
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset with straps s, then random pin and core traffic
  task automatic run(input logic [3:0] s);
    logic [7:0] d;
    logic [7:0] p;
    logic [23:0] e;
    @(posedge core_clk);
    rst <= 1'b1;
    ext_lvl <= {4'hf, s};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk("strap_value", strap_value, s);
    chk("mode", mode, s[`PFM_STRAP_C]);
    chk("host_dma_en", host_dma_en, s[`PFM_STRAP_C]);
    chk("byte_dma_en", byte_dma_en, !s[`PFM_STRAP_C]);
    repeat (24) begin
      @(posedge core_clk);
      st <= {$random(seed), $random(seed), $random(seed), $random(seed)};
      ext_lvl <= 8'($random(seed));
      repeat (5) @(posedge core_clk);
      #1;
      d = {st[15:12], st[7:4]};
      p = (d & {st[11:8], st[3:0]}) | (~d & ext_lvl);
      chk("flag_lo_in", core_flag_lo_in, p[3:0]);
      chk("flag_hi_in", core_flag_hi_in, p[7:4]);
      chk("irq_request", irq_request, 4'(~p[7:4] & st[19:16]));
      chk("flag_oe_n", strap_flag_oe_n, 4'(~st[7:4]));
      chk("strap_value", strap_value, s);
      chk("sport_dt_out", sport_dt_out, st[20] ? st[28] : st[27]);
      e = s[2] ? {13'h0000, st[32]} : st[45:32];
      if (!s[`PFM_STRAP_C])
        chk("address", ext_address_out, st[45:32]);
      else
        chk("address", ext_address_out, e);
      chk("addr_oe_n", ext_address_oe_n, 1'b0);
      e = {st[22] & ~st[25], st[23] & ~st[24]};
      chk("sport_irq", sport_irq, e);
      chk("flag_in", serial_flag_in, st[21] & st[26]);
      e = {st[21] ? 1'b0 : st[26], st[22] ? 1'b0 : st[25],
           st[23] ? 1'b0 : st[24]};
      chk("sport_core_in", sport_core_in, e);
      e = !s[2] | (s[3] & !st[31]);
      chk("ack_oe_n", host_acknowledge_oe_n, e);
      chk("ack_out", host_acknowledge_out, !s[3] & !st[31]);
      e = s[2] ? {st[111:96], st[55:48]} : st[111:88];
      chk("data_out", ext_data_out, e);
      e = {{16{!st[29]}}, {8{s[2] ? !st[30] : !st[29]}}};
      chk("data_oe_n", ext_data_oe_n, e);
      e = s[2] ? {st[87:72], 8'h00} : st[87:64];
      chk("rdata", core_rdata, e);
      e = s[2] ? {st[45:38], st[71:64]} : 24'h000000;
      chk("host_bus", host_addr_data_bus, e);
      e = s[2] ? st[71:68] : 4'hd;
      chk("host_ctl", host_ctl, e);
    end
  endtask
  initial begin
    seed = 85613;
    fails = 0;
    tests_run = 0;
    rst = 1'b1;
    st = '0;
    ext_lvl = 8'hff;
    run(4'hc);
    run(4'($random(seed)) & 4'hb);
    test_done();
  end
  initial begin
    #1000000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
